// ### rtl/lcr_pkg.sv
package lcr_pkg;

   // ********************************************************************
   // Register indices; the byte address on the bus is four times these.
   // ********************************************************************
   localparam logic [7:0] IDX_CMD    = 8'h03;
   localparam logic [7:0] IDX_LCTL   = 8'h04;
   localparam logic [7:0] IDX_LSTAT  = 8'h05;
   localparam logic [7:0] IDX_ISTAT  = 8'h08;
   localparam logic [7:0] IDX_IEN    = 8'h09;
   localparam logic [7:0] IDX_IRQ_LO = 8'h08;
   localparam logic [7:0] IDX_IRQ_HI = 8'h0b;

   // ********************************************************************
   // Field positions and reset values.
   // ********************************************************************
   localparam int          CMD_SRST_BIT  = 0;
   localparam int          LCTL_DIV_LSB  = 0;
   localparam int          LCTL_AUTO_BIT = 4;
   localparam int          LCTL_SEL_LSB  = 5;
   localparam int          LCTL_PULS_BIT = 7;
   localparam logic [7:0]  LCTL_RST      = 8'h00;
   localparam logic [5:0]  IEN_RST       = 6'h00;
   localparam int          NUM_EVT       = 6;

   // ********************************************************************
   // Timing counts, in clock cycles, half clocks or prescaled clocks.
   // ********************************************************************
   localparam logic [3:0]  OSC_SETTLE_CYC = 4'h8;
   localparam logic [3:0]  SLOT_TICKS     = 4'hf;
   localparam logic [3:0]  SAMPLE_POS     = 4'h8;
   localparam logic [3:0]  PULSE_TICKS    = 4'h2;
   localparam logic [9:0]  HALF_BASE_POW2 = 10'h002;
   localparam logic [9:0]  HALF_BASE_1P5  = 10'h003;

endpackage

// ### rtl/lcr_prescaler.sv
// Prescaled clock enable: one pulse every n clocks, n from the divider code.
// Fractional 1.5 steps are made by counting in half clocks, so the pulse
// spacing alternates by one clock but the average rate is exact.
module lcr_prescaler #(
   parameter int ACC_W = 10
) (
   input  wire logic       clock_i,  // System clock.
   input  wire logic       clear_i,  // Holds the divider at zero.
   input  wire logic [3:0] code_i,   // Clock divider code.
   output logic            tick_o    // One-cycle prescaled clock enable.
);

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic             tick;
   } lcr_psc_t;

   lcr_psc_t         s;
   lcr_psc_t         next_s;
   logic [ACC_W-1:0] period;
   logic [ACC_W-1:0] sum;

   // ********************************************************************
   // Period in half clocks: 2 or 3 shifted by the low code bits.
   // ********************************************************************
   always_comb begin
      period = (code_i[3] ? lcr_pkg::HALF_BASE_1P5 : lcr_pkg::HALF_BASE_POW2) << code_i[2:0];
      sum    = ACC_W'(s.acc + lcr_pkg::HALF_BASE_POW2);
      next_s = s;
      next_s.tick = 1'b0;
      if (sum >= period) begin
         // A code change can leave the count above a shorter period; restarting
         // it then avoids a long burst of back-to-back ticks.
         next_s.acc  = (ACC_W'(sum - period) >= period) ? '0 : ACC_W'(sum - period);
         next_s.tick = 1'b1;
      end else begin
         next_s.acc = sum;
      end
      if (clear_i) begin
         next_s = '0;
      end
   end

   // Register the state.
   always_ff @(posedge clock_i) begin
      s <= next_s;
   end

   assign tick_o = s.tick;

endmodule

// ### rtl/lcr_line_diag.sv
// Line diagnosis: each input is scored against the majority of the three.
// A disagreement costs more than an agreement earns back, so a line that
// glitches now and then is dropped quickly and recovers slowly.
module lcr_line_diag #(
   parameter int SCORE_W = 6
) (
   input  wire logic       clock_i,   // System clock.
   input  wire logic       clear_i,   // Clears all scores.
   input  wire logic       sample_i,  // Sample point pulse.
   input  wire logic [2:0] lines_i,   // Synchronised line levels.
   output logic [1:0]      best_o     // Index of the most reliable line.
);

   typedef struct packed {
      logic [2:0][SCORE_W-1:0] score;
      logic [1:0]              best;
   } lcr_diag_t;

   lcr_diag_t  s;
   lcr_diag_t  next_s;
   logic       major;
   logic [2:0] miss;

   assign major = (lines_i[0] & lines_i[1]) | (lines_i[1] & lines_i[2])
                | (lines_i[0] & lines_i[2]);

   // Per-line disagreement with the majority.
   for (genvar g = 0; g < 3; g++) begin : g_miss
      assign miss[g] = lines_i[g] ^ major;
   end

   // ********************************************************************
   // Score update and choice of the lowest score, lowest index on a tie.
   // ********************************************************************
   always_comb begin
      next_s = s;
      if (sample_i) begin
         for (int i = 0; i < 3; i++) begin
            if (miss[i]) begin
               next_s.score[i] = (s.score[i] > SCORE_W'(2**SCORE_W - 5))
                               ? '1 : SCORE_W'(s.score[i] + SCORE_W'(4));
            end else if (s.score[i] != '0) begin
               next_s.score[i] = SCORE_W'(s.score[i] - SCORE_W'(1));
            end
         end
      end
      next_s.best = 2'd0;
      if (s.score[1] < s.score[0]) begin
         next_s.best = 2'd1;
      end
      if (s.score[2] < s.score[next_s.best]) begin
         next_s.best = 2'd2;
      end
      if (clear_i) begin
         next_s = '0;
      end
   end

   // Register the state.
   always_ff @(posedge clock_i) begin
      s <= next_s;
   end

   assign best_o = s.best;

endmodule

// ### rtl/lcr_front_end.sv
// Operation
// - Attention request is active-low open-drain, gated by an enable register.
// - Any access to interrupt registers 08h to 0Bh releases the attention request.
// - Reset comes from the reset pin or software, asynchronous to the clock.
// - Writing the soft reset bit of command register 03h performs a full reset.
// - Pin and soft reset are ORed and filtered; oscillator enabled in reset.
// - Eight clock periods are counted after the reset source ends before release.
// - Internal reset releases synchronously; without clock the block stays reset.
// - Buffered clock output is a non-inverted copy of the crystal clock.
// - Prescaled clock is crystal frequency divided by n; slot is sixteen of them.
// - Codes 0 to 7 select factors 1, 2, 4 up to 128.
// - Codes 8 to 15 select factors 1.5, 3, 6 up to 192.
// - Receive input is fixed by software or chosen automatically.
// - Automatic mode compares all inputs at each sample point and picks the most reliable.
// - High is recessive one, low dominant zero; own data is received back.
// - Sending recessive while dominant is received loses arbitration harmlessly.
// - Pulsed mode sends dominant as a two-prescaled-clock low pulse at bit start.
// - Pulsed mode receiver decodes edges, not levels.
// - Pulsed mode forces reception onto line input zero.
// - Pulsed mode loops transmitted data back to the receiver internally.
// - A timeslot is sixteen prescaled clocks in both modes; pulsed mode shortens only the dominant low.
// - Clearing one interrupt while another pends gives a one-strobe high pulse.
// - Buffered clock output is enabled only outside reset.
module lcr_front_end (
   input  wire logic        clock_i,               // Crystal clock, 20 MHz.
   input  wire logic        rst_i,                 // Synchronous reset, high.
   input  wire logic        hsel_i,                // AHB slave select.
   input  wire logic [31:0] haddr_i,               // AHB address.
   input  wire logic [1:0]  htrans_i,              // AHB transfer type.
   input  wire logic        hwrite_i,              // AHB write.
   input  wire logic [2:0]  hsize_i,               // AHB size, word only.
   input  wire logic [31:0] hwdata_i,              // AHB write data.
   input  wire logic        hready_i,              // AHB bus ready.
   output logic [31:0]      hrdata_o,              // AHB read data.
   output logic             hreadyout_o,           // AHB slave ready.
   output logic             hresp_o,               // AHB response, OKAY.
   input  wire logic        reset_pin_i,           // External reset pin, high.
   input  wire logic        line_input_zero_i,     // Line input zero.
   input  wire logic        line_input_one_i,      // Line input one.
   input  wire logic        line_input_two_i,      // Line input two.
   input  wire logic        tx_en_i,               // Protocol engine transmits.
   input  wire logic        tx_bit_i,              // Bit for next timeslot.
   input  wire logic [4:0]  evt_i,                 // Protocol event pulses.
   output logic             txd_o,                 // Line output.
   output logic             irq_n_o,               // Attention request level.
   output logic             irq_oe_n_o,            // Attention drive, low drives.
   output logic             buffered_clock_out_en_o, // Clock pad enable.
   output logic             osc_en_o,              // Oscillator enable.
   output logic             core_rst_o,            // Internal reset, high.
   output logic             prescaled_slot_clock_o, // Prescaled clock pulse.
   output logic             slot_start_o,          // Timeslot start pulse.
   output logic             rx_bit_o,              // Received slot bit.
   output logic             rx_valid_o,            // Received bit strobe.
   output logic             arb_lost_o,            // Arbitration lost level.
   output logic [1:0]       line_sel_o             // Selected receive input.
);

   typedef struct packed {
      logic        rp_s1;
      logic        rp_s2;
      logic [2:0]  ln_s1;
      logic [2:0]  ln_s2;
      logic        ln0_d;
      logic [3:0]  rst_cnt;
      logic        core_rst;
      logic        srst_req;
      logic        dp_valid;
      logic        dp_write;
      logic [7:0]  dp_idx;
      logic [31:0] hrdata;
      logic [7:0]  lctl;
      logic [5:0]  istat;
      logic [5:0]  ien;
      logic        arb_lost;
      logic        tx_act;
      logic        tx_bit;
      logic [3:0]  pos;
      logic        edge_seen;
      logic        rx_bit;
      logic        rx_valid;
      logic        txd;
      logic        irq_oe_n;
      logic        ck_en;
      logic        ptick;
      logic        slot;
      logic [1:0]  sel;
   } lcr_fe_t;

   lcr_fe_t    s;
   lcr_fe_t    next_s;
   logic       ptick;
   logic [1:0] diag_best;
   logic       sample;
   logic       a_phase;
   logic [7:0] a_idx;
   logic       irq_acc;
   logic       pulsed;
   logic       sel_lvl;
   logic       rx_now;
   logic       own_dom;
   logic [5:0] set_evt;
   logic [5:0] clr_evt;

   // Decodes a word address into a register index.
   function automatic logic [7:0] reg_index(input logic [31:0] addr);
      return addr[9:2];
   endfunction

   // True for an index that falls among the interrupt registers.
   function automatic logic is_irq_reg(input logic [7:0] idx);
      return (idx >= lcr_pkg::IDX_IRQ_LO) && (idx <= lcr_pkg::IDX_IRQ_HI);
   endfunction

   // ********************************************************************
   // Prescaler and line diagnosis.
   // ********************************************************************
   lcr_prescaler #(
      .ACC_W (10)
   ) i_lcr_prescaler (
      .clock_i (clock_i),
      .clear_i (s.core_rst),
      .code_i  (s.lctl[lcr_pkg::LCTL_DIV_LSB +: 4]),
      .tick_o  (ptick)
   );

   lcr_line_diag #(
      .SCORE_W (6)
   ) i_lcr_line_diag (
      .clock_i  (clock_i),
      .clear_i  (s.core_rst),
      .sample_i (sample),
      .lines_i  (s.ln_s2),
      .best_o   (diag_best)
   );

   // Helper terms shared by the next-state logic.
   assign pulsed  = s.lctl[lcr_pkg::LCTL_PULS_BIT];
   assign sample  = ptick && (s.pos == lcr_pkg::SAMPLE_POS);
   assign a_phase = hsel_i && htrans_i[1] && hready_i;
   assign a_idx   = reg_index(haddr_i);
   assign irq_acc = a_phase && is_irq_reg(a_idx);
   assign sel_lvl = s.ln_s2[s.sel];
   assign own_dom = s.tx_act && !s.tx_bit;

   // ********************************************************************
   // Next-state logic.
   // ********************************************************************
   always_comb begin
      next_s = s;
      set_evt = '0;
      clr_evt = '0;
      rx_now = sel_lvl;

      // Pin inputs pass two flip-flops before anything reads them.
      next_s.rp_s1 = reset_pin_i;
      next_s.rp_s2 = s.rp_s1;
      next_s.ln_s1 = {line_input_two_i, line_input_one_i, line_input_zero_i};
      next_s.ln_s2 = s.ln_s1;
      next_s.ln0_d = s.ln_s2[0];

      next_s.srst_req = 1'b0;
      if (s.rp_s2 || s.srst_req) begin
         next_s.core_rst = 1'b1;
         next_s.rst_cnt  = '0;
      end else if (s.core_rst) begin
         if (s.rst_cnt == 4'(lcr_pkg::OSC_SETTLE_CYC - 4'h1)) begin
            next_s.core_rst = 1'b0;
         end else begin
            next_s.rst_cnt = 4'(s.rst_cnt + 4'h1);
         end
      end
      next_s.ck_en = !next_s.core_rst;

      // Bus address phase: capture it and prepare read data in one cycle.
      next_s.dp_valid = a_phase;
      next_s.dp_write = hwrite_i;
      next_s.dp_idx   = a_idx;
      if (a_phase && !hwrite_i) begin
         unique case (a_idx)
            lcr_pkg::IDX_LCTL:  next_s.hrdata = {24'h000000, s.lctl};
            lcr_pkg::IDX_LSTAT: next_s.hrdata = {28'h0000000, s.core_rst, s.arb_lost, s.sel};
            lcr_pkg::IDX_ISTAT: next_s.hrdata = {26'h0000000, s.istat};
            lcr_pkg::IDX_IEN:   next_s.hrdata = {26'h0000000, s.ien};
            default:            next_s.hrdata = '0;
         endcase
      end

      // Bus data phase: writes take effect here.
      if (s.dp_valid && s.dp_write) begin
         unique case (s.dp_idx)
            lcr_pkg::IDX_CMD:   next_s.srst_req = hwdata_i[lcr_pkg::CMD_SRST_BIT];
            lcr_pkg::IDX_LCTL:  next_s.lctl = hwdata_i[7:0];
            lcr_pkg::IDX_ISTAT: clr_evt = hwdata_i[5:0];
            lcr_pkg::IDX_IEN:   next_s.ien = hwdata_i[5:0];
            default:            next_s.lctl = s.lctl;
         endcase
      end

      if (pulsed) begin
         next_s.sel = 2'd0;
      end else if (s.lctl[lcr_pkg::LCTL_AUTO_BIT]) begin
         next_s.sel = diag_best;
      end else begin
         next_s.sel = (s.lctl[lcr_pkg::LCTL_SEL_LSB +: 2] == 2'd3)
                    ? 2'd2 : s.lctl[lcr_pkg::LCTL_SEL_LSB +: 2];
      end

      if (s.ln0_d && !s.ln_s2[0]) begin
         next_s.edge_seen = 1'b1;
      end

      next_s.ptick    = ptick;
      next_s.slot     = 1'b0;
      next_s.rx_valid = 1'b0;
      if (ptick) begin
         next_s.pos = 4'(s.pos + 4'h1);
         if (s.pos == lcr_pkg::SLOT_TICKS) begin
            next_s.slot      = 1'b1;
            next_s.tx_act    = tx_en_i && !s.arb_lost;
            next_s.tx_bit    = tx_bit_i;
            next_s.edge_seen = 1'b0;
            if (!tx_en_i) begin
               next_s.arb_lost = 1'b0;
            end
         end
      end

      if (pulsed) begin
         rx_now = !(s.edge_seen || own_dom);
      end
      if (sample) begin
         next_s.rx_bit   = rx_now;
         next_s.rx_valid = 1'b1;
         if (s.tx_act && s.tx_bit && !rx_now) begin
            next_s.arb_lost = 1'b1;
            next_s.tx_act   = 1'b0;
            set_evt[5]      = 1'b1;
         end
      end

      if (pulsed) begin
         next_s.txd = !(next_s.tx_act && !next_s.tx_bit && (next_s.pos < lcr_pkg::PULSE_TICKS));
      end else begin
         next_s.txd = !(next_s.tx_act && !next_s.tx_bit);
      end

      // Event flags: a new event wins over a clear in the same cycle.
      set_evt[4:0] = evt_i;
      next_s.istat = (s.istat & ~clr_evt) | set_evt;

      next_s.irq_oe_n = !(|(next_s.istat & next_s.ien) && !irq_acc);

      // A full reset returns the control state to its defaults.
      if (next_s.core_rst) begin
         next_s.lctl     = lcr_pkg::LCTL_RST;
         next_s.ien      = lcr_pkg::IEN_RST;
         next_s.istat    = '0;
         next_s.arb_lost = 1'b0;
         next_s.tx_act   = 1'b0;
         next_s.pos      = '0;
         next_s.txd      = 1'b1;
         next_s.irq_oe_n = 1'b1;
         next_s.ptick    = 1'b0;
         next_s.slot     = 1'b0;
         next_s.rx_valid = 1'b0;
      end
   end

   // ********************************************************************
   // State register.
   // ********************************************************************
   // The internal reset enters on the first edge after the pin is seen, so
   // a stopped clock leaves the block in reset until edges resume.
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         s          <= '0;
         s.core_rst <= 1'b1;
         s.txd      <= 1'b1;
         s.irq_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // ********************************************************************
   // Outputs.
   // ********************************************************************
   assign hrdata_o                = s.hrdata;
   assign hreadyout_o             = 1'b1;      // Zero wait states.
   assign hresp_o                 = 1'b0;      // Always OKAY.
   assign txd_o                   = s.txd;
   assign irq_n_o                 = 1'b0;      // Open drain only pulls low.
   assign irq_oe_n_o              = s.irq_oe_n;
   assign buffered_clock_out_en_o = s.ck_en;
   assign osc_en_o                = 1'b1;
   assign core_rst_o              = s.core_rst;
   assign prescaled_slot_clock_o  = s.ptick;
   assign slot_start_o            = s.slot;
   assign rx_bit_o                = s.rx_bit;
   assign rx_valid_o              = s.rx_valid;
   assign arb_lost_o              = s.arb_lost;
   assign line_sel_o              = s.sel;

endmodule

// ### tb/lcr_properties.sv
module lcr_properties (
   input wire logic        clock_i,                 // Clock.
   input wire logic        rst_i,                   // Reset.
   input wire logic        hsel_i,                  // Select.
   input wire logic [31:0] haddr_i,                 // Address.
   input wire logic [1:0]  htrans_i,                // Transfer.
   input wire logic        hready_i,                // Ready.
   input wire logic        reset_pin_i,             // Pin reset.
   input wire logic        buffered_clock_out_en_o, // Clock pad on.
   input wire logic        core_rst_o,              // Core reset.
   input wire logic        irq_oe_n_o,              // Attention drive.
   input wire logic        prescaled_slot_clock_o,  // Tick.
   input wire logic        slot_start_o,            // Slot start.
   input wire logic        rx_valid_o,              // Rx strobe.
   input wire logic        rx_bit_o,                // Rx bit.
   input wire logic        arb_lost_o               // Arbitration lost.
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (rst_i);
   // ****
   // Sequences
   // ****
   // Address phase to the attention registers.
   sequence s_irq_acc;
      hsel_i && htrans_i[1] && hready_i && haddr_i[31:2] >= 30'h8 && haddr_i[31:2] <= 30'hb;
   endsequence
   // A held reset is counted out before release.
   sequence s_settle;
      core_rst_o [*7] ##[1:3] !core_rst_o;
   endsequence
   // ****
   // Assertions
   // ****
   // The pin reset is seen through its synchroniser, so allow a few edges.
   a_rst_follow: assert property (disable iff (1'b0) rst_i |=> core_rst_o)
      else $error("core reset missing");
   a_rst_release: assert property ($fell(rst_i) |-> s_settle)
      else $error("bad reset release");
   a_pin_reset: assert property ($rose(reset_pin_i) |-> ##[1:4] core_rst_o)
      else $error("pin reset ignored");
   a_core_hold: assert property ($rose(core_rst_o) |-> core_rst_o [*8])
      else $error("reset too short");
   a_clk_enable: assert property ($stable(core_rst_o) |-> buffered_clock_out_en_o != core_rst_o)
      else $error("clock pad enable wrong");
   a_quiet_reset: assert property (core_rst_o && $past(core_rst_o) |-> !prescaled_slot_clock_o && !slot_start_o)
      else $error("ticks in reset");
   a_irq_release: assert property (s_irq_acc |=> irq_oe_n_o)
      else $error("attention not released");
   a_slot_tick: assert property (slot_start_o |-> prescaled_slot_clock_o)
      else $error("slot without tick");
   a_rx_hold: assert property (!rx_valid_o && !core_rst_o |-> $stable(rx_bit_o))
      else $error("rx bit moved");
   a_arb_sample: assert property ($rose(arb_lost_o) |-> rx_valid_o)
      else $error("loss off sample");
endmodule

// ### tb/lcr_line_model.sv
module lcr_line_model (
   input  wire logic       txd_i,  // Device output.
   input  wire logic       opt_i,  // Optical link.
   input  wire logic [2:0] jam_i,  // Other station dominant.
   output logic [2:0]      line_o  // Receiver levels.
);
   timeunit 1ns;
   timeprecision 1ns;
   // wired dominant low
   // Low wins on the wire, so one dominant party pulls the receivers low.
   assign line_o[2:1] = {2{txd_i}} & ~jam_i[2:1];
   // optical no echo
   // An optical receiver never sees its own light, only the other party.
   assign line_o[0] = (txd_i | opt_i) & ~jam_i[0];
endmodule

// ### tb/lcr_front_end_tb.sv
module lcr_front_end_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock_i, rst_i, hsel, hwrite, hready, pin_rst, tx_en, tx_bit, opt;
   logic        txd, irq_oe_n, ck_en, core_rst, ptick, slot, rx_bit, arb, dp_irq, post_irq;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, line_sel;
   logic [4:0]  evt;
   logic        hresp, irq_pin, osc_en;
   logic [2:0]  jam, line;
   int          miscompares, n_compared, k, i;
   lcr_front_end i_lcr_front_end (
      .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .reset_pin_i(pin_rst), .line_input_zero_i(line[0]), .line_input_one_i(line[1]),
      .line_input_two_i(line[2]), .tx_en_i(tx_en), .tx_bit_i(tx_bit), .evt_i(evt),
      .txd_o(txd), .irq_n_o(irq_pin), .irq_oe_n_o(irq_oe_n), .buffered_clock_out_en_o(ck_en),
      .osc_en_o(osc_en), .core_rst_o(core_rst), .prescaled_slot_clock_o(ptick),
      .slot_start_o(slot), .rx_bit_o(rx_bit), .rx_valid_o(), .arb_lost_o(arb),
      .line_sel_o(line_sel));
   lcr_line_model i_lcr_line_model (.txd_i(txd), .opt_i(opt), .jam_i(jam), .line_o(line));
   // ****
   // Helpers
   // ****
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (miscompares == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // One single transfer; the attention drive is noted in and after the data phase.
   task bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      @(posedge clock_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {22'h0, idx, 2'b00};
      hwrite <= wr;
      do @(posedge clock_i); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clock_i); while (hready !== 1'b1);
      rd = hrdata;
      dp_irq = irq_oe_n;
      @(posedge clock_i);
      post_irq = irq_oe_n;
   endtask
   task w_rst(input logic v);
      do @(posedge clock_i); while (core_rst !== v);
   endtask
   task w_slot;
      do @(posedge clock_i); while (slot !== 1'b1);
   endtask
   // Sends one bit; counts low cycles of the line output over a whole slot.
   task send(input logic b, input int low, input logic r);
      tx_bit <= b;
      w_slot;
      w_slot;
      k = 0;
      repeat (16) begin
         k += (txd === 1'b0);
         @(posedge clock_i);
      end
      chk(k, low);
      chk(rx_bit, r);
   endtask
   // ****
   // Scenarios
   // ****
   task t_irq;
      bus(1, lcr_pkg::IDX_IEN, 32'h3f);
      evt <= 5'h03;
      @(posedge clock_i);
      evt <= 5'h00;
      repeat (3) @(posedge clock_i);
      chk(irq_oe_n, 0);
      for (int a = 8; a < 12; a++) begin
         bus(0, a, 0);
         chk({dp_irq, post_irq}, 2'b10);
      end
      bus(1, lcr_pkg::IDX_ISTAT, 32'h1);
      chk({dp_irq, post_irq}, 2'b10);
      bus(0, lcr_pkg::IDX_ISTAT, 0);
      chk(rd, 32'h2);
      bus(1, lcr_pkg::IDX_ISTAT, 32'h2);
      chk({dp_irq, post_irq}, 2'b11);
      bus(1, lcr_pkg::IDX_IEN, 32'h0);
      evt <= 5'h10;
      @(posedge clock_i);
      evt <= 5'h00;
      repeat (3) @(posedge clock_i);
      chk(irq_oe_n, 1);
   endtask
   // The first two slots after a code change are skipped, as the first may be partial.
   task t_div;
      for (int c = 0; c < 16; c++) begin
         bus(1, lcr_pkg::IDX_LCTL, c);
         w_slot;
         w_slot;
         k = 0;
         i = 0;
         do begin
            @(posedge clock_i);
            k++;
            i += (ptick === 1'b1);
         end while (slot !== 1'b1);
         chk(k, c < 8 ? 16 << c : 24 << (c - 8));
         chk(i, 16);
      end
   endtask
   task t_line;
      bus(1, lcr_pkg::IDX_LCTL, 32'h20);
      tx_en <= 1'b1;
      send(0, 16, 0);
      send(1, 0, 1);
      chk(line_sel, 2'd1);
      jam <= 3'b010;
      send(1, 0, 0);
      chk(arb, 1);
      jam <= 3'b000;
      send(0, 0, 1);
      tx_en <= 1'b0;
      jam <= 3'b010;
      bus(1, lcr_pkg::IDX_LCTL, 32'h40);
      send(1, 0, 1);
      jam <= 3'b100;
      bus(1, lcr_pkg::IDX_LCTL, 32'h10);
      repeat (40) w_slot;
      chk(line_sel !== 2'd2, 1);
   endtask
   // Other lines are jammed; in this mode they must not matter.
   task t_pulse;
      opt <= 1'b1;
      jam <= 3'b110;
      bus(1, lcr_pkg::IDX_LCTL, 32'h80);
      tx_en <= 1'b1;
      send(0, 2, 0);
      send(1, 0, 1);
      chk(line_sel, 2'd0);
      tx_en <= 1'b0;
      w_slot;
      jam <= 3'b111;
      repeat (2) @(posedge clock_i);
      jam <= 3'b110;
      repeat (12) @(posedge clock_i);
      chk(rx_bit, 0);
      opt <= 1'b0;
      jam <= 3'b000;
   endtask
   task t_resets;
      for (int s = 0; s < 2; s++) begin
         bus(1, lcr_pkg::IDX_LCTL, 32'h87);
         if (s == 0) begin
            bus(1, lcr_pkg::IDX_CMD, 32'h1);
         end else begin
            pin_rst <= 1'b1;
            @(posedge clock_i);
            pin_rst <= 1'b0;
         end
         w_rst(1);
         w_rst(0);
         @(posedge clock_i);
         chk(ck_en, 1);
         bus(0, lcr_pkg::IDX_LCTL, 0);
         chk(rd, 0);
      end
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      {rst_i, hsel, hwrite, pin_rst, tx_en, tx_bit, opt} = 7'h40;
      {haddr, hwdata, htrans, evt, jam} = '0;
      repeat (8) @(posedge clock_i);
      chk(core_rst, 1);
      chk(ck_en, 0);
      chk(osc_en, 1);
      chk({hresp, irq_pin}, 2'b00);
      rst_i <= 1'b0;
      w_rst(0);
      bus(0, lcr_pkg::IDX_LCTL, 0);
      chk(rd, lcr_pkg::LCTL_RST);
      bus(0, 8'h30, 0);
      chk(rd, 0);
      t_irq;
      t_div;
      t_line;
      t_pulse;
      t_resets;
      test_done;
   end
   // Watchdog; the divider sweep dominates the run at about 31000 cycles.
   initial begin
      repeat (80000) @(posedge clock_i);
      miscompares++;
      test_done;
   end
endmodule

bind lcr_front_end lcr_properties i_lcr_properties (
   .clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
   .htrans_i(htrans_i), .hready_i(hready_i), .reset_pin_i(reset_pin_i),
   .buffered_clock_out_en_o(buffered_clock_out_en_o), .core_rst_o(core_rst_o),
   .irq_oe_n_o(irq_oe_n_o), .prescaled_slot_clock_o(prescaled_slot_clock_o),
   .slot_start_o(slot_start_o), .rx_valid_o(rx_valid_o), .rx_bit_o(rx_bit_o),
   .arb_lost_o(arb_lost_o));
